// >>> pdm_pkg.sv
/*
 Constants for the program and data address map of an 8-bit core.
 Assumes one core clock and a synchronous active-high reset.
*/
package pdm_pkg;
	localparam int PC_W           = 13;
	localparam int FILE_W         = 7;
	localparam int DADDR_W        = 8;
	localparam int DATA_W         = 8;
	localparam int SFR_COUNT      = 32;
	localparam int RAM_WORDS      = 128;
	localparam int RAM_AW         = 7;
	localparam logic [PC_W-1:0] RESET_VEC  = 13'h0000;
	localparam logic [PC_W-1:0] INTR_VEC   = 13'h0004;
	localparam logic [PC_W-1:0] SMALL_MASK = 13'h03FF;
	localparam logic [PC_W-1:0] LARGE_MASK = 13'h07FF;
	localparam logic [DADDR_W-1:0] SMALL_RAM_LO = 8'h40;
	localparam logic [DADDR_W-1:0] SMALL_RAM_HI = 8'h7F;
	localparam logic [DADDR_W-1:0] B0_RAM_LO    = 8'h20;
	localparam logic [DADDR_W-1:0] B0_RAM_HI    = 8'h7F;
	localparam logic [DADDR_W-1:0] B1_RAM_LO    = 8'hA0;
	localparam logic [DADDR_W-1:0] B1_RAM_HI    = 8'hBF;
	localparam logic [DADDR_W-1:0] MIRROR_LO    = 8'hF0;
	localparam logic [DADDR_W-1:0] MIRROR_HI    = 8'hFF;
	localparam logic [DADDR_W-1:0] MIRROR_BASE  = 8'h70;
	localparam logic [DATA_W-1:0]  ZERO_DATA    = 8'h00;
	// One-hot: ram or sfr or nothing
	typedef enum logic [2:0] {
		PDM_HIT_NONE = 3'b001,
		PDM_HIT_SFR  = 3'b010,
		PDM_HIT_RAM  = 3'b100
	} pdm_hit_t;
endpackage

// >>> pdm_data_decode.sv
/*
 Combinational data address decoder: region and RAM index.
 Assumes the caller registers its outputs.
*/
`timescale 1ns/100ps
module pdm_data_decode
(
	input  wire logic                          large_variant,
	input  wire logic [pdm_pkg::DADDR_W-1:0]   addr,
	output pdm_pkg::pdm_hit_t                  hit,
	output logic      [pdm_pkg::RAM_AW-1:0]    ram_index
);
	logic [pdm_pkg::DADDR_W-1:0] phys;

	always_comb
	begin
		phys = addr;
		// (R9) Mirror window
		if (addr >= pdm_pkg::MIRROR_LO)
			phys = pdm_pkg::MIRROR_BASE + (addr - pdm_pkg::MIRROR_LO);
		hit = pdm_pkg::PDM_HIT_NONE;
		ram_index = '0;
		// (R6) Low 32 of each bank
		if (addr[pdm_pkg::FILE_W-1:0] < pdm_pkg::FILE_W'(pdm_pkg::SFR_COUNT))
			hit = pdm_pkg::PDM_HIT_SFR;
		// (R7) Small variant RAM
		else if (!large_variant && phys >= pdm_pkg::SMALL_RAM_LO && phys <= pdm_pkg::SMALL_RAM_HI)
		begin
			hit = pdm_pkg::PDM_HIT_RAM;
			ram_index = phys[pdm_pkg::RAM_AW-1:0];
		end
		// (R8) Large variant RAM, bank 0 rows
		else if (large_variant && phys >= pdm_pkg::B0_RAM_LO && phys <= pdm_pkg::B0_RAM_HI)
		begin
			hit = pdm_pkg::PDM_HIT_RAM;
			ram_index = phys[pdm_pkg::RAM_AW-1:0];
		end
		// (R8) Large variant RAM, bank 1 rows
		else if (large_variant && phys >= pdm_pkg::B1_RAM_LO && phys <= pdm_pkg::B1_RAM_HI)
		begin
			hit = pdm_pkg::PDM_HIT_RAM;
			// Bank 1 rows fold onto unused 00h-1Fh cells
			ram_index = phys[pdm_pkg::RAM_AW-1:0] - pdm_pkg::B1_RAM_LO[pdm_pkg::RAM_AW-1:0];
		end
	end
endmodule

// >>> pdm_address_map.sv
/*
 Program and data address map: program counter with wrap and vectors,
 banked data decode, general purpose RAM, zero reads when unmapped.
 Assumes fetch and operand logic of the core drive the strobes,
 and special register contents come back on sfr_rdata.
*/
// Behaviour
// (R1) Program counter is 13 bits, spanning 8K words of 14 bits.
// (R2) Only 1K words (small) or 2K words to 07FFh (large) exist.
// (R3) Fetches above the implemented region wrap, low bits decoded only.
// (R4) Reset starts at 0000h; interrupt entry jumps to 0004h.
// (R5) Data memory has two banks, each with special regs and RAM.
// (R6) Lowest 32 addresses of each bank are special function registers.
// (R7) Small variant: bank 0 40h-7Fh is general purpose RAM.
// (R8) Large variant: RAM at bank 0 20h-7Fh and bank 1 A0h-BFh.
// (R9) Bank 1 F0h-FFh reach the same cells as bank 0 70h-7Fh.
// (R10) Unmapped data addresses read as zero.
// (R11) Bank select bit 0 chooses bank 0, 1 chooses bank 1.
// (R12) Software keeps indirect page and upper bank bits at zero.
// (R13) Direct address is bank select bit above 7-bit file address.
`timescale 1ns/100ps
module pdm_address_map
(
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          large_variant,
	input  wire logic                          pc_load,
	input  wire logic [pdm_pkg::PC_W-1:0]      pc_load_value,
	input  wire logic                          pc_step,
	input  wire logic                          intr_enter,
	input  wire logic                          bank_select_bit,
	input  wire logic                          data_rd,
	input  wire logic                          data_wr,
	input  wire logic [pdm_pkg::FILE_W-1:0]    file_addr,
	input  wire logic [pdm_pkg::DATA_W-1:0]    data_wdata,
	input  wire logic [pdm_pkg::DATA_W-1:0]    sfr_rdata,
	output logic      [pdm_pkg::PC_W-1:0]      pc,
	output logic      [pdm_pkg::PC_W-1:0]      prog_addr,
	output logic      [pdm_pkg::DATA_W-1:0]    data_rdata,
	output logic                               data_valid,
	output logic                               sfr_sel,
	output logic      [pdm_pkg::DADDR_W-1:0]   data_addr
);
	typedef struct packed {
		logic [pdm_pkg::PC_W-1:0]    pc;
		logic [pdm_pkg::PC_W-1:0]    prog_addr;
		logic [pdm_pkg::DATA_W-1:0]  data_rdata;
		logic                        data_valid;
		logic                        sfr_sel;
		logic [pdm_pkg::DADDR_W-1:0] data_addr;
	} pdm_state_t;

	pdm_state_t                    st;
	pdm_state_t                    next_st;
	logic [pdm_pkg::DATA_W-1:0]    ram [pdm_pkg::RAM_WORDS];
	logic [pdm_pkg::DADDR_W-1:0]   eff_addr;
	logic [pdm_pkg::PC_W-1:0]      pc_mask;
	logic [pdm_pkg::PC_W-1:0]      next_pc;
	pdm_pkg::pdm_hit_t             hit;
	logic [pdm_pkg::RAM_AW-1:0]    ram_index;

	// (R13) Effective direct address
	// (R11) Bank bit picks bank
	assign eff_addr = {bank_select_bit, file_addr};
	// (R2) Implemented size
	assign pc_mask = large_variant ? pdm_pkg::LARGE_MASK : pdm_pkg::SMALL_MASK;

	// (R5) Two banked decode
	pdm_data_decode u_decode
	(
		.large_variant (large_variant),
		.addr          (eff_addr),
		.hit           (hit),
		.ram_index     (ram_index)
	);

	always_comb
	begin
		next_st = st;
		next_pc = st.pc;
		// (R4) Interrupt beats load and step
		if (intr_enter)
			next_pc = pdm_pkg::INTR_VEC;
		else if (pc_load)
			next_pc = pc_load_value;
		else if (pc_step)
			// (R1) Full 13-bit count
			next_pc = st.pc + pdm_pkg::PC_W'(1);
		next_st.pc = next_pc;
		// (R3) Wrap into present words
		next_st.prog_addr = next_pc & pc_mask;
		next_st.data_valid = data_rd;
		next_st.data_addr = eff_addr;
		next_st.sfr_sel = (data_rd || data_wr) && hit == pdm_pkg::PDM_HIT_SFR;
		// (R10) Unmapped reads zero
		next_st.data_rdata = pdm_pkg::ZERO_DATA;
		if (data_rd)
		begin
			unique case (hit)
				pdm_pkg::PDM_HIT_SFR:  next_st.data_rdata = sfr_rdata;
				pdm_pkg::PDM_HIT_RAM:  next_st.data_rdata = ram[ram_index];
				pdm_pkg::PDM_HIT_NONE: next_st.data_rdata = pdm_pkg::ZERO_DATA;
			endcase
		end
		if (sys_rst)
		begin
			// (R4) Reset vector
			next_st = '0;
			next_st.pc = pdm_pkg::RESET_VEC;
			next_st.prog_addr = pdm_pkg::RESET_VEC;
		end
	end

	always_ff @(posedge clk)
	begin
		st <= next_st;
	end

	// RAM cells hold no reset, as on silicon
	// (R9) Mirror shares cells
	always_ff @(posedge clk)
	begin
		if (data_wr && hit == pdm_pkg::PDM_HIT_RAM)
			ram[ram_index] <= data_wdata;
	end

	assign pc         = st.pc;
	assign prog_addr  = st.prog_addr;
	assign data_rdata = st.data_rdata;
	assign data_valid = st.data_valid;
	assign sfr_sel    = st.sfr_sel;
	assign data_addr  = st.data_addr;

	sequence reset_seen;
		sys_rst;
	endsequence
	sequence intr_seen;
		intr_enter && !sys_rst;
	endsequence
	sequence ram_write_seen;
		data_wr && hit == pdm_pkg::PDM_HIT_RAM;
	endsequence
	sequence same_cell_read;
		data_rd && !data_wr && eff_addr == $past(eff_addr);
	endsequence
	sequence mirror_write_seen;
		data_wr && large_variant && bank_select_bit
			&& file_addr >= pdm_pkg::MIRROR_BASE[pdm_pkg::FILE_W-1:0];
	endsequence
	sequence mirror_read_seen;
		data_rd && !data_wr && !bank_select_bit && file_addr == $past(file_addr);
	endsequence
	sequence sfr_read_seen;
		data_rd && hit == pdm_pkg::PDM_HIT_SFR;
	endsequence

	// (R4) Reset vector
	reset_vector_a: assert property (@(posedge clk) reset_seen |=> pc == pdm_pkg::RESET_VEC) // (R4)
		else $error("pc not at reset vector");

	// (R4) Reset clears outputs
	reset_clear_a: assert property (@(posedge clk) reset_seen |=> prog_addr == pdm_pkg::RESET_VEC // (R4)
		&& data_rdata == pdm_pkg::ZERO_DATA && !data_valid && !sfr_sel && data_addr == '0)
		else $error("outputs not cleared by reset");

	// (R4) Interrupt vector
	intr_vector_a: assert property (@(posedge clk) intr_seen |=> prog_addr == pdm_pkg::INTR_VEC) // (R4)
		else $error("interrupt vector missed");

	// (R3) Wrap into region
	prog_wrap_a: assert property (@(posedge clk) disable iff (sys_rst) // (R3)
		(prog_addr & ~(large_variant ? pdm_pkg::LARGE_MASK : pdm_pkg::SMALL_MASK)) == '0)
		else $error("program address outside implemented region");

	// (R2) Low pc bits only
	prog_alias_a: assert property (@(posedge clk) disable iff (sys_rst) // (R2)
		prog_addr == (pc & (large_variant ? pdm_pkg::LARGE_MASK : pdm_pkg::SMALL_MASK)))
		else $error("program address not the low pc bits");

	// (R1) Counter steps
	pc_count_a: assert property (@(posedge clk) disable iff (sys_rst) // (R1)
		pc_step && !pc_load && !intr_enter |=> pc == $past(pc) + pdm_pkg::PC_W'(1))
		else $error("pc did not advance");

	// (R1) Full width load
	pc_load_a: assert property (@(posedge clk) disable iff (sys_rst) // (R1)
		pc_load && !intr_enter |=> pc == $past(pc_load_value))
		else $error("pc did not load");

	// (R11) Bank bit on top
	eff_addr_a: assert property (@(posedge clk) disable iff (sys_rst) // (R11)
		data_rd |=> data_addr[pdm_pkg::DADDR_W-1] == $past(bank_select_bit))
		else $error("bank bit not in address");

	// (R6) Low rows select
	sfr_low_a: assert property (@(posedge clk) disable iff (sys_rst) // (R6)
		data_rd && file_addr < pdm_pkg::FILE_W'(pdm_pkg::SFR_COUNT) |=> sfr_sel)
		else $error("low address did not select special regs");

	// (R6) Higher rows never select
	sfr_high_a: assert property (@(posedge clk) disable iff (sys_rst) // (R6)
		(data_rd || data_wr) && file_addr >= pdm_pkg::FILE_W'(pdm_pkg::SFR_COUNT) |=> !sfr_sel)
		else $error("high address selected special regs");

	// (R6) Special data passes
	sfr_data_a: assert property (@(posedge clk) disable iff (sys_rst) // (R6)
		sfr_read_seen |=> data_rdata == $past(sfr_rdata))
		else $error("special register data lost");

	// (R10) Unmapped reads zero
	unmapped_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // (R10)
		data_rd && hit == pdm_pkg::PDM_HIT_NONE |=> data_rdata == pdm_pkg::ZERO_DATA)
		else $error("unmapped read not zero");

	// (R10) Idle bus reads zero
	rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // (R10)
		!data_rd |=> data_rdata == pdm_pkg::ZERO_DATA)
		else $error("read data not zero when idle");

	// (R10) Read answer marked
	read_valid_a: assert property (@(posedge clk) disable iff (sys_rst) // (R10)
		data_rd |=> data_valid)
		else $error("read answer not marked valid");

	// (R10) No read, no mark
	idle_valid_a: assert property (@(posedge clk) disable iff (sys_rst) // (R10)
		!data_rd |=> !data_valid)
		else $error("valid without a read");

	// (R9) Mirror shares cells
	mirror_rw_a: assert property (@(posedge clk) disable iff (sys_rst) // (R9)
		mirror_write_seen ##1 mirror_read_seen |=> data_rdata == $past(data_wdata, 2))
		else $error("mirror window not shared");

	// (R7) Written cell reads back
	ram_readback_a: assert property (@(posedge clk) disable iff (sys_rst) // (R7)
		ram_write_seen ##1 same_cell_read |=> data_rdata == $past(data_wdata, 2))
		else $error("ram cell did not hold write");

	// (R7) Small variant gap
	small_ram_a: assert property (@(posedge clk) disable iff (sys_rst) // (R7)
		data_rd && !large_variant && !bank_select_bit
		&& file_addr < pdm_pkg::SMALL_RAM_LO[pdm_pkg::FILE_W-1:0]
		&& file_addr >= pdm_pkg::B0_RAM_LO[pdm_pkg::FILE_W-1:0]
		|=> data_rdata == pdm_pkg::ZERO_DATA)
		else $error("small variant gap not zero");

	// (R8) Bank 1 gap
	bank1_ram_a: assert property (@(posedge clk) disable iff (sys_rst) // (R8)
		data_rd && large_variant && bank_select_bit
		&& file_addr > pdm_pkg::B1_RAM_HI[pdm_pkg::FILE_W-1:0]
		&& file_addr < pdm_pkg::MIRROR_BASE[pdm_pkg::FILE_W-1:0]
		|=> data_rdata == pdm_pkg::ZERO_DATA)
		else $error("bank 1 gap not zero");
endmodule

// >>> pdm_core_model.sv
/*
 Model of the core operand logic that answers special register reads.
 Assumes the bench drives direct accesses on falling clock edges.
*/
`timescale 1ns/100ps
module pdm_core_model
(
	input  wire logic                       clk,
	input  wire logic                       data_rd,
	input  wire logic                       bank_select_bit,
	input  wire logic [pdm_pkg::FILE_W-1:0] file_addr,
	output logic      [pdm_pkg::DATA_W-1:0] sfr_rdata
);
	logic [pdm_pkg::DATA_W-1:0] churn = 8'h00;
	// Idle value churns, so a stale byte never passes for a read
	always @(posedge clk) churn <= churn + 8'h01;
	// Read answer is the bank bit and file address XOR A5h
	assign sfr_rdata = data_rd ? ({bank_select_bit, file_addr} ^ 8'hA5) : churn;
endmodule

// >>> tb_top.sv
/*
 Self-checking bench for the address map, run once per variant.
 Assumes the core model answers special register reads.
*/
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, sys_rst = 1, large_variant = 0, pc_load = 0, pc_step = 0, intr_enter = 0;
	logic bank_select_bit = 0, data_rd = 0, data_wr = 0;
	logic [12:0] pc_load_value = 13'h0000, pc, prog_addr, mask;
	logic [6:0]  file_addr = 7'h00;
	logic [7:0]  data_wdata = 8'h00, sfr_rdata, data_rdata, data_addr;
	logic        data_valid, sfr_sel;
	int          n_mismatch = 0, checks_done = 0;
	always #4 clk = ~clk;
	pdm_address_map pdm_address_map_i (.clk(clk), .sys_rst(sys_rst), .large_variant(large_variant),
		.pc_load(pc_load), .pc_load_value(pc_load_value), .pc_step(pc_step), .intr_enter(intr_enter),
		.bank_select_bit(bank_select_bit), .data_rd(data_rd), .data_wr(data_wr), .file_addr(file_addr),
		.data_wdata(data_wdata), .sfr_rdata(sfr_rdata), .pc(pc), .prog_addr(prog_addr),
		.data_rdata(data_rdata), .data_valid(data_valid), .sfr_sel(sfr_sel), .data_addr(data_addr));
	pdm_core_model pdm_core_model_i (.clk(clk), .data_rd(data_rd), .bank_select_bit(bank_select_bit),
		.file_addr(file_addr), .sfr_rdata(sfr_rdata));
	task automatic chk_pc(input string nm, input logic [12:0] e, input logic [12:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e)
		begin
			$display("mismatch %s expected %b seen %b", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic pgm(input logic i, input logic l, input logic s, input logic [12:0] v);
		@(negedge clk);
		{intr_enter, pc_load, pc_step, pc_load_value} = {i, l, s, v};
		@(negedge clk);
		{intr_enter, pc_load, pc_step} = 3'b000;
	endtask
	task automatic acc(input logic w, input logic b, input logic [6:0] fa, input logic [7:0] d);
		@(negedge clk);
		{data_wr, data_rd, bank_select_bit, file_addr, data_wdata} = {w, !w, b, fa, d};
		@(negedge clk);
		{data_wr, data_rd} = 2'b00;
		chk_byte("data_addr", {b, fa}, data_addr);
		chk_bit("sfr_sel", fa < 7'h20, sfr_sel);
		chk_bit("data_valid", !w, data_valid);
	endtask
	task automatic rd(input logic b, input logic [6:0] fa, input logic [7:0] e);
		acc(1'b0, b, fa, 8'h00);
		chk_byte("data_rdata", e, data_rdata);
	endtask
	task automatic wr_rd(input logic bw, input logic br, input logic [6:0] fa, input logic [7:0] d,
		input logic [7:0] e);
		@(negedge clk);
		{data_wr, data_rd, bank_select_bit, file_addr, data_wdata} = {1'b1, 1'b0, bw, fa, d};
		@(negedge clk);
		{data_wr, data_rd, bank_select_bit} = {1'b0, 1'b1, br};
		chk_byte("data_addr", {bw, fa}, data_addr);
		@(negedge clk);
		data_rd = 1'b0;
		chk_byte("data_addr", {br, fa}, data_addr);
		chk_bit("data_valid", 1'b1, data_valid);
		chk_byte("data_rdata", e, data_rdata);
	endtask
	task automatic t_prog();
		chk_pc("pc", 13'h0000, pc);
		chk_pc("prog_addr", 13'h0000, prog_addr);
		pgm(1'b0, 1'b1, 1'b0, 13'h1FFF);
		chk_pc("pc", 13'h1FFF, pc);
		chk_pc("prog_addr", mask, prog_addr);
		pgm(1'b0, 1'b0, 1'b1, 13'h0000);
		chk_pc("pc", 13'h0000, pc);
		pgm(1'b0, 1'b1, 1'b1, 13'h0ABC);
		chk_pc("prog_addr", 13'h0ABC & mask, prog_addr);
		pgm(1'b1, 1'b1, 1'b1, 13'h0123);
		chk_pc("pc", 13'h0004, pc);
		chk_pc("prog_addr", 13'h0004, prog_addr);
		pgm(1'b0, 1'b0, 1'b1, 13'h0000);
		chk_pc("pc", 13'h0005, pc);
		pgm(1'b0, 1'b1, 1'b0, 13'h0C00);
		chk_pc("pc", 13'h0C00, pc);
		chk_pc("prog_addr", 13'h0C00 & mask, prog_addr);
		$display("test prog done");
	endtask
	task automatic t_data();
		acc(1'b1, 1'b0, 7'h70, 8'h5A);
		rd(1'b1, 7'h70, 8'h5A);
		acc(1'b1, 1'b1, 7'h20, 8'h3C);
		rd(1'b1, 7'h20, large_variant ? 8'h3C : 8'h00);
		acc(1'b1, 1'b0, 7'h20, 8'h77);
		rd(1'b0, 7'h20, large_variant ? 8'h77 : 8'h00);
		acc(1'b1, 1'b0, 7'h40, 8'h11);
		rd(1'b0, 7'h40, 8'h11);
		rd(1'b1, 7'h40, 8'h00);
		rd(1'b0, 7'h05, 8'h05 ^ 8'hA5);
		rd(1'b1, 7'h1F, 8'h9F ^ 8'hA5);
		rd(1'b0, 7'h40, 8'h11);
		$display("test data done");
	endtask
	task automatic t_mirror();
		wr_rd(1'b1, 1'b0, 7'h75, 8'h96, 8'h96);
		wr_rd(1'b0, 1'b1, 7'h7E, 8'h6B, 8'h6B);
		wr_rd(1'b0, 1'b0, 7'h50, 8'hE1, 8'hE1);
		wr_rd(1'b1, 1'b1, 7'h25, 8'hC3, large_variant ? 8'hC3 : 8'h00);
		wr_rd(1'b0, 1'b0, 7'h30, 8'h4D, large_variant ? 8'h4D : 8'h00);
		$display("test back to back done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		for (int v = 0; v < 2; v++)
		begin
			@(negedge clk);
			{sys_rst, large_variant} = {1'b1, v[0]};
			mask = v[0] ? 13'h07FF : 13'h03FF;
			repeat (5) @(negedge clk);
			sys_rst = 0;
			t_prog();
			t_data();
			t_mirror();
		end
		tally_and_finish();
	end
	// Whole run needs about 115 cycles
	initial
	begin
		#(2000 * 8);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
